// ==== testbench.sv ====
// Bench for the queue control block.
// Assumes ufc_top, its checker and the line model.
`include "ufc_map.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_n_in, ce_in, wr_in, rd_in, tx_wr_valid_in, tx_wr_ready_out;
  logic tx_sh_valid_out, tx_sh_ready_in, rx_sh_valid_in, rx_sh_ready_out, rx_rd_valid_out;
  logic rx_rd_ready_in, rx_timeout_in, rx_threshold_hit_out, stall, sok;
  logic tx_dma_request_n_out, rx_dma_request_n_out;
  logic [1:0] addr_in;
  logic [7:0] wdata_in, rdata_out, tx_wr_data_in, tx_sh_data_out, rx_sh_data_in;
  logic [7:0] rx_rd_data_out;
  int err_total, n_tests;
  ufc_top uut (.*);
  ufc_line_model line (.clk_in(clk_in), .stall_in(stall), .tx_valid_in(tx_sh_valid_out),
    .tx_data_in(tx_sh_data_out), .tx_ready_out(tx_sh_ready_in),
    .rx_valid_out(rx_sh_valid_in), .rx_data_out(rx_sh_data_in),
    .rx_ready_in(rx_sh_ready_out));
  // ------------
  // Helpers
  // ------------
  initial
  begin
    clk_in = 1'h0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic results;
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      err_total++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'h1;
    addr_in <= `UFC_OFS_CTRL;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_in);
    rd_in <= 1'h1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1 chk(rdata_out & m, e);
  endtask
  task automatic snd(input logic [7:0] d);
    line.send(d, sok);
    if (!sok)
    begin
      err_total++;
      results;
    end
  endtask
  task automatic push(input logic [7:0] d);
    logic ok;
    @(posedge clk_in);
    tx_wr_valid_in <= 1'h1;
    tx_wr_data_in <= d;
    ok = 1'h0;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge clk_in);
      ok = tx_wr_ready_out;
    end
    tx_wr_valid_in <= 1'h0;
    if (!ok)
    begin
      err_total++;
      results;
    end
  endtask
  // ------------
  // Scenarios
  // ------------
  task automatic t_rx0;
    wr(8'h01);
    snd(8'hA5);
    cyc(3);
    chk(8'(rx_dma_request_n_out), 8'h00);
    chk(rx_rd_data_out, 8'hA5);
    chk(8'(rx_threshold_hit_out), 8'h01);
    rx_rd_ready_in <= 1'h1;
    cyc(4);
    rx_rd_ready_in <= 1'h0;
    chk(8'(rx_dma_request_n_out), 8'h01);
    chk(8'(rx_threshold_hit_out), 8'h00);
  endtask
  task automatic t_thresh;
    int n[4] = '{1, 4, 8, 14};
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h0B | 8'(c << 6));
      repeat (n[c] - 1) snd(8'(c));
      cyc(3);
      chk(8'(rx_dma_request_n_out), 8'h01);
      chk(8'(rx_threshold_hit_out), 8'h00);
      snd(8'h3C);
      cyc(3);
      chk(8'(rx_dma_request_n_out), 8'h00);
      chk(8'(rx_threshold_hit_out), 8'h01);
    end
    snd(8'h00);
    snd(8'hFF);
    cyc(3);
    chk(8'(rx_sh_ready_out), 8'h00);
    rd(`UFC_OFS_RXLVL, 8'hFF, 8'h10);
    wr(8'hCB);
    rd(`UFC_OFS_RXLVL, 8'hFF, 8'h00);
    chk(8'(rx_dma_request_n_out), 8'h01);
    snd(8'h11);
    rx_timeout_in <= 1'h1;
    cyc(1);
    rx_timeout_in <= 1'h0;
    cyc(2);
    chk(8'(rx_dma_request_n_out), 8'h00);
    wr(8'hCB);
  endtask
  task automatic t_tx;
    wr(8'h0D);
    for (int i = 0; i < 16; i++)
      push(8'(i));
    cyc(3);
    chk(8'(tx_dma_request_n_out), 8'h01);
    chk(8'(tx_wr_ready_out), 8'h00);
    wr(8'h0D);
    cyc(3);
    chk(8'(tx_dma_request_n_out), 8'h00);
    rd(`UFC_OFS_TXLVL, 8'hFF, 8'h00);
    wr(8'h01);
    stall <= 1'h0;
    push(8'h5A);
    cyc(2);
    chk(8'(tx_dma_request_n_out), 8'h01);
    cyc(4);
    chk(8'(line.got.size()), 8'h01);
    chk(line.got[0], 8'h5A);
    chk(8'(tx_dma_request_n_out), 8'h00);
  endtask
  task automatic t_en;
    logic [7:0] seq[4] = '{8'h08, 8'h09, 8'h08, 8'h01};
    logic [7:0] st[4] = '{8'h00, 8'h0C, 8'h08, 8'h04};
    for (int i = 0; i < 4; i++)
    begin
      wr(seq[i]);
      rd(`UFC_OFS_STATUS, 8'h0C, st[i]);
    end
  endtask
  task automatic t_ce;
    @(posedge clk_in);
    ce_in <= 1'h0;
    wr(8'h09);
    ce_in <= 1'h1;
    rd(`UFC_OFS_STATUS, 8'h0C, 8'h04);
    rst_n_in <= 1'h0;
    cyc(2);
    rst_n_in <= 1'h1;
    chk(8'(rx_dma_request_n_out), 8'h01);
    rd(`UFC_OFS_STATUS, 8'h0C, 8'h00);
  endtask
  initial
  begin
    err_total = 0;
    n_tests = 0;
    {rst_n_in, wr_in, rd_in, tx_wr_valid_in, rx_rd_ready_in, rx_timeout_in} = 6'h00;
    {addr_in, wdata_in, tx_wr_data_in} = 18'h00000;
    ce_in = 1'h1;
    stall = 1'h1;
    cyc(6);
    rst_n_in <= 1'h1;
    chk(8'(tx_dma_request_n_out), 8'h00);
    chk(8'(rx_dma_request_n_out), 8'h01);
    rd(`UFC_OFS_CTRL, 8'hFF, 8'h00);
    t_rx0;
    t_thresh;
    t_tx;
    t_en;
    t_ce;
    results;
  end
endmodule
`default_nettype wire

// ==== ufc_line_model.sv ====
// Line side model: drains transmit characters, feeds receive ones.
// Assumes the bench clock; stall_in holds the transmit side off.
`default_nettype none
module ufc_line_model (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  initial
  begin
    tx_ready_out = 1'h0;
    rx_valid_out = 1'h0;
    rx_data_out = 8'h00;
  end
  always @(posedge clk_in)
  begin
    if (tx_valid_in && tx_ready_out)
      got.push_back(tx_data_in);
    tx_ready_out <= !stall_in;
  end
  // Released data is inverted so a stale byte never passes for a fresh one
  task automatic send(input logic [7:0] d, output logic ok);
    @(posedge clk_in);
    rx_valid_out <= 1'h1;
    rx_data_out <= d;
    ok = 1'h0;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge clk_in);
      ok = rx_ready_in;
    end
    rx_valid_out <= 1'h0;
    rx_data_out <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== ufc_map.vh ====
// Register map, field positions, reset values and depths for the queue control block.
// Assumes a plain register port on clk_in; no package, constants as macros.
`ifndef UFC_MAP_VH
`define UFC_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UFC_ADDR_W 2
`define UFC_OFS_CTRL 2'h0
`define UFC_OFS_STATUS 2'h1
`define UFC_OFS_TXLVL 2'h2
`define UFC_OFS_RXLVL 2'h3
// ----------------------------------------
// Control fields
// ----------------------------------------
`define UFC_BIT_EN 0
`define UFC_BIT_RXCLR 1
`define UFC_BIT_TXCLR 2
`define UFC_BIT_MODE 3
`define UFC_TH_HI 7
`define UFC_TH_LO 6
`define UFC_CTRL_RST 8'h00
// ----------------------------------------
// Queue sizes and thresholds
// ----------------------------------------
`define UFC_DATA_W 8
`define UFC_QDEPTH 16
`define UFC_QAW 4
`define UFC_CNT_W 5
`define UFC_TH_1 5'h01
`define UFC_TH_4 5'h04
`define UFC_TH_8 5'h08
`define UFC_TH_14 5'h0E
`define UFC_CNT_FULL 5'h10
`endif

// ==== ufc_sva.sv ====
// Checker on the queue control ports.
// Assumes a registered read port; checks pause while ce_in is low.
`include "ufc_map.vh"
`default_nettype none
module ufc_sva (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic tx_wr_valid_in,
  input wire logic tx_wr_ready_out,
  input wire logic tx_sh_valid_out,
  input wire logic rx_sh_valid_in,
  input wire logic rx_sh_ready_out,
  input wire logic rx_rd_valid_out,
  input wire logic rx_timeout_in,
  input wire logic tx_dma_request_n_out,
  input wire logic rx_dma_request_n_out
);
  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in || !ce_in);
  // Clear with no new character arriving, else the queue may refill at once
  sequence s_clr(b, v);
    wr_in && addr_in == `UFC_OFS_CTRL && wdata_in[0] && wdata_in[b] && !v;
  endsequence
  a_reset_levels: assert property ($past(!rst_n_in) |->
    !tx_dma_request_n_out && rx_dma_request_n_out) else $error("reset levels");
  a_ctrl_read_zero: assert property (rd_in && addr_in == `UFC_OFS_CTRL |=>
    rdata_out == 8'h00) else $error("control read");
  a_tx_take_gap: assert property (tx_wr_valid_in && tx_wr_ready_out |=>
    !tx_wr_ready_out) else $error("tx gap");
  a_rx_take_gap: assert property (rx_sh_valid_in && rx_sh_ready_out |=>
    !rx_sh_ready_out) else $error("rx gap");
  a_tx_clear_empty: assert property (s_clr(2, tx_wr_valid_in) |->
    ##[1:2] !tx_sh_valid_out) else $error("tx clear");
  a_rx_clear_empty: assert property (s_clr(1, rx_sh_valid_in) |->
    ##[1:2] !rx_rd_valid_out) else $error("rx clear");
  a_rx_idle_high: assert property ((!rx_rd_valid_out && !rx_sh_valid_in
    && !rx_timeout_in)[*4] |-> rx_dma_request_n_out) else $error("rx idle");
  a_tx_idle_low: assert property ((!tx_sh_valid_out && !tx_wr_valid_in)[*4]
    |-> !tx_dma_request_n_out) else $error("tx idle");
endmodule
bind ufc_top ufc_sva u_sva (.*);
`default_nettype wire

// ==== ufc_top.v ====
// Queue control, two sixteen-entry character queues and DMA request outputs.
// Assumes character source/sink and receive timeout on clk_in; pins from outside
// are not involved, so no synchronisers are needed.
//
// Chosen here: strobed register access and the register offsets.
`include "ufc_map.vh"
`default_nettype none

// ----------------------------------------
// Parameterised queue
// ----------------------------------------
module ufc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire clr_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [AW:0] count_out
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready_out = (cnt_r != DEPTH[AW:0]);
  assign out_valid_out = (cnt_r != {(AW+1){1'b0}});
  assign out_data_out = mem_r[rp_r];
  assign count_out = cnt_r;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  // A push that meets a clear is dropped with the rest of the queue
  always @(posedge clk_in)
  begin
    if (push && ce_in && !clr_in)
    begin
      mem_r[wp_r] <= in_data_in;
    end
  end
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else if (ce_in)
    begin
      if (clr_in)
      begin
        // Pointers and count only; the shift register outside is left alone
        wp_r <= {AW{1'b0}};
        rp_r <= {AW{1'b0}};
        cnt_r <= {(AW+1){1'b0}};
      end
      else
      begin
        if (push)
        begin
          wp_r <= wp_r + 1'b1;
        end
        if (pop)
        begin
          rp_r <= rp_r + 1'b1;
        end
        if (push && !pop)
        begin
          cnt_r <= cnt_r + 1'b1;
        end
        else if (pop && !push)
        begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end
endmodule

// ----------------------------------------
// Top
// ----------------------------------------
module ufc_top (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire [`UFC_ADDR_W-1:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire tx_wr_valid_in,
  output reg tx_wr_ready_out,
  input wire [`UFC_DATA_W-1:0] tx_wr_data_in,
  output reg tx_sh_valid_out,
  input wire tx_sh_ready_in,
  output reg [`UFC_DATA_W-1:0] tx_sh_data_out,
  input wire rx_sh_valid_in,
  output reg rx_sh_ready_out,
  input wire [`UFC_DATA_W-1:0] rx_sh_data_in,
  output reg rx_rd_valid_out,
  input wire rx_rd_ready_in,
  output reg [`UFC_DATA_W-1:0] rx_rd_data_out,
  input wire rx_timeout_in,
  output reg rx_threshold_hit_out,
  output reg tx_dma_request_n_out,
  output reg rx_dma_request_n_out
);
  // ----------------------------------------
  // Control register
  // ----------------------------------------
  reg enable_r;
  reg mode_r;
  reg [1:0] rx_threshold_select_r;
  reg tx_queue_clear_r;
  reg rx_queue_clear_r;
  reg rx_block_r;
  reg [`UFC_CNT_W-1:0] th_cnt;
  wire ctrl_wr;
  wire tx_in_v;
  wire tx_in_rdy;
  wire tx_out_v;
  wire tx_out_rdy;
  wire [`UFC_DATA_W-1:0] tx_out_d;
  wire [`UFC_CNT_W-1:0] tx_cnt;
  wire rx_in_v;
  wire rx_in_rdy;
  wire rx_out_v;
  wire rx_out_rdy;
  wire [`UFC_DATA_W-1:0] rx_out_d;
  wire [`UFC_CNT_W-1:0] rx_cnt;
  wire rx_hit;
  wire tx_empty_nxt;
  wire rx_empty_nxt;
  wire tx_full;
  wire rx_req_hold;

  assign ctrl_wr = wr_in && (addr_in == `UFC_OFS_CTRL);

  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      enable_r <= 1'b0;
      mode_r <= 1'b0;
      rx_threshold_select_r <= 2'b00;
      tx_queue_clear_r <= 1'b0;
      rx_queue_clear_r <= 1'b0;
    end
    else if (ce_in)
    begin
      // Clear bits last one cycle, then fall back to zero
      tx_queue_clear_r <= 1'b0;
      rx_queue_clear_r <= 1'b0;
      if (ctrl_wr)
      begin
        enable_r <= wdata_in[`UFC_BIT_EN];
        if (wdata_in[`UFC_BIT_EN])
        begin
          mode_r <= wdata_in[`UFC_BIT_MODE];
          rx_threshold_select_r <= wdata_in[`UFC_TH_HI:`UFC_TH_LO];
          tx_queue_clear_r <= wdata_in[`UFC_BIT_TXCLR];
          rx_queue_clear_r <= wdata_in[`UFC_BIT_RXCLR];
        end
      end
    end
  end

  // ----------------------------------------
  // Threshold decode
  // ----------------------------------------
  always @*
  begin
    case (rx_threshold_select_r)
      2'b00: th_cnt = `UFC_TH_1;
      2'b01: th_cnt = `UFC_TH_4;
      2'b10: th_cnt = `UFC_TH_8;
      default: th_cnt = `UFC_TH_14;
    endcase
  end

  // ----------------------------------------
  // Queues
  // ----------------------------------------
  // Disabled queues act as a single holding register: depth limited to one
  assign tx_in_v = tx_wr_valid_in && tx_wr_ready_out;
  // The count gates the host so a full queue refuses the next character
  assign tx_in_rdy = enable_r ? !tx_full : tx_empty_nxt;
  assign tx_out_rdy = tx_sh_ready_in && tx_sh_valid_out;
  assign rx_in_v = rx_sh_valid_in && rx_sh_ready_out;
  assign rx_out_rdy = rx_rd_ready_in && rx_rd_valid_out;

  ufc_fifo #(.WIDTH(`UFC_DATA_W), .DEPTH(`UFC_QDEPTH), .AW(`UFC_QAW)) u_txq (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .clr_in(tx_queue_clear_r),
    .in_valid_in(tx_in_v),
    .in_ready_out(),
    .in_data_in(tx_wr_data_in),
    .out_valid_out(tx_out_v),
    .out_ready_in(tx_out_rdy),
    .out_data_out(tx_out_d),
    .count_out(tx_cnt)
  );

  ufc_fifo #(.WIDTH(`UFC_DATA_W), .DEPTH(`UFC_QDEPTH), .AW(`UFC_QAW)) u_rxq (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .clr_in(rx_queue_clear_r),
    .in_valid_in(rx_in_v),
    .in_ready_out(rx_in_rdy),
    .in_data_in(rx_sh_data_in),
    .out_valid_out(rx_out_v),
    .out_ready_in(rx_out_rdy),
    .out_data_out(rx_out_d),
    .count_out(rx_cnt)
  );

  // ----------------------------------------
  // Request outputs
  // ----------------------------------------
  // Equal is reached first; at or above keeps it up until the count drops below
  assign rx_hit = enable_r && (rx_cnt >= th_cnt);
  assign tx_empty_nxt = (tx_cnt == {`UFC_CNT_W{1'b0}});
  assign rx_empty_nxt = (rx_cnt == {`UFC_CNT_W{1'b0}});
  assign tx_full = (tx_cnt == `UFC_CNT_FULL);
  // Held from threshold or timeout until the queue is empty, released on that edge
  assign rx_req_hold = (rx_block_r || rx_hit || rx_timeout_in) && !rx_empty_nxt;

  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rx_block_r <= 1'b0;
      tx_wr_ready_out <= 1'b0;
      tx_sh_valid_out <= 1'b0;
      tx_sh_data_out <= 8'h00;
      rx_sh_ready_out <= 1'b0;
      rx_rd_valid_out <= 1'b0;
      rx_rd_data_out <= 8'h00;
      rx_threshold_hit_out <= 1'b0;
      tx_dma_request_n_out <= 1'b0;
      rx_dma_request_n_out <= 1'b1;
      rdata_out <= 8'h00;
    end
    else if (ce_in)
    begin
      // Handshake outputs are registered; drop after a take to avoid a double pop
      tx_wr_ready_out <= tx_in_rdy && !tx_in_v;
      // A clear withdraws the queued character at once so a stale one never leaks
      tx_sh_valid_out <= tx_out_v && !tx_out_rdy && !tx_queue_clear_r;
      tx_sh_data_out <= tx_out_d;
      // Accepts past the threshold, stops at full, or once one character is held while disabled
      rx_sh_ready_out <= rx_in_rdy && !rx_in_v && (enable_r || rx_empty_nxt);
      rx_rd_valid_out <= rx_out_v && !rx_out_rdy && !rx_queue_clear_r;
      rx_rd_data_out <= rx_out_d;
      rx_threshold_hit_out <= rx_hit;
      // Block mode: latch on threshold or timeout until empty
      if (!enable_r || !mode_r || rx_empty_nxt)
      begin
        rx_block_r <= 1'b0;
      end
      else if (rx_hit || rx_timeout_in)
      begin
        rx_block_r <= 1'b1;
      end
      if (enable_r && mode_r)
      begin
        tx_dma_request_n_out <= tx_full;
        rx_dma_request_n_out <= !rx_req_hold;
      end
      else
      begin
        tx_dma_request_n_out <= !tx_empty_nxt;
        rx_dma_request_n_out <= rx_empty_nxt;
      end
      // ----------------------------------------
      // Read port
      // ----------------------------------------
      rdata_out <= 8'h00;
      if (rd_in)
      begin
        case (addr_in)
          `UFC_OFS_STATUS: rdata_out <= {3'b000, rx_block_r, mode_r, enable_r,
                                         tx_empty_nxt, rx_empty_nxt};
          `UFC_OFS_TXLVL: rdata_out <= {3'b000, tx_cnt};
          `UFC_OFS_RXLVL: rdata_out <= {3'b000, rx_cnt};
          default: rdata_out <= 8'h00; // Control is write-only
        endcase
      end
    end
  end
endmodule
`default_nettype wire
